//--- erpc_master_model.sv
// Cyclic control-word sender standing in for the bus master.
`timescale 1ns/1ps
module erpc_master_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Commanded control bits 15 down to 11.
	input wire logic [4:0] cmd,
	// Cyclic output.
	output logic ctrl_valid,
	output logic [15:0] ctrl_word
);
	// Sends every other cycle, so a changed command reaches the block within three edges.
	always_ff @(posedge clk) begin
		ctrl_valid <= !srst && !ctrl_valid;
		ctrl_word <= {cmd, 11'h000};
	end
endmodule // erpc_master_model

//--- erpc_param_check.sv
// Acceptance check for a new range and scaling parameter set.
`timescale 1ns/1ps
module erpc_param_check import erpc_pkg::*; #(
	parameter int ST_BITS = ERPC_ST_BITS_DEF,
	parameter int MT_BITS = ERPC_MT_BITS_DEF
) (
	// Candidate values.
	input wire logic [31:0] units_per_turn,
	input wire logic [31:0] total_range,
	input wire logic [31:0] total_range_hi,
	input wire logic [31:0] total_range_lo,
	// Verdict.
	output logic accept,
	output logic [63:0] eff_range
);
	logic [63:0] range64;
	logic [63:0] range32;
	logic [63:0] upt64;
	// Halves are joined as quotient and remainder of the division by 2^32.
	assign range64 = {total_range_hi, total_range_lo}; // R04
	assign range32 = {32'h00000000, total_range};
	assign upt64 = {32'h00000000, units_per_turn};
	// The wide value wins only when the narrow one is zero or agrees with it.
	always_comb begin
		eff_range = (range64 != 64'h0) ? range64 : range32;
		accept = 1'b1;
		if (range64 != 64'h0 && range32 != 64'h0 && range64 != range32) begin
			accept = 1'b0; // R05
		end
		if (range64 == 64'h0 && range32 == 64'h0) begin
			accept = 1'b0; // R05
		end
		if (range32 != 64'h0 && range32 < ERPC_RANGE_MIN) begin
			accept = 1'b0; // R02
		end
		if (eff_range < ERPC_RANGE_MIN || upt64 < ERPC_RANGE_MIN) begin
			accept = 1'b0;
		end
		if (upt64 > (64'h1 << ST_BITS)) begin
			accept = 1'b0; // R07
		end
		if (eff_range > (upt64 << MT_BITS)) begin
			accept = 1'b0; // R07
		end
		if (MT_BITS == 0 && eff_range != upt64) begin
			accept = 1'b0; // R06
		end
	end
endmodule // erpc_param_check

//--- erpc_pkg.sv
// Constants, state types and modular helpers for the encoder range and preset control block.
// What the document requires
// R01 - Position wraps to zero past the total range and keeps counting.
// R02 - Thirty-two bit total range must be 2 up to 2^32-1, else rejected.
// R03 - Master uses the 64-bit range and telegram 84 for larger ranges.
// R04 - 64-bit range arrives as upper half (value div 2^32) and lower remainder.
// R05 - Reject when both ranges are nonzero and differ, or both are zero.
// R06 - Singleturn device: total range must equal units per turn.
// R07 - Scaled singleturn and multiturn resolution must not exceed the physical ones.
// R08 - Default units per turn equal singleturn count; range is singleturn times multiturn.
// R09 - In compatibility mode the life-sign error limit is ten times the setting.
// R10 - Speed unit: steps per second, per 10 ms, per 100 ms, or RPM.
// R11 - Step-based speed follows the configured position scaling.
// R12 - Control word: 15 ack, 14 park, 13 abs request, 12 preset, 11 relative.
// R13 - Acknowledge bit marks the shown error code as acknowledged.
// R14 - Park sets status bit 14, invalidates position, silences error handling.
// R15 - Absolute request shows the position in position word two; the code ignores bit 13 and shows it when not in error, not parked and the range fits 32 bits.
// R16 - Preset handshake: request, executed, request cleared, executed cleared.
// R17 - Relative preset adds the signed preset value to the position.
// R18 - Absolute preset loads the position with the preset value.
// R19 - Master should request presets only at standstill.
// R20 - Offset is never written; it is computed from preset and position.
// R21 - 64-bit preset and offset mirror their 32-bit counterparts.
// R22 - Class 4 off: no presets, clockwise counting, default scaling.
// R23 - A switch selects whether presets reach word one; words two and three always.
// R24 - With sensor error set, word two carries the error code.
// R25 - Only a rising preset request starts a preset.
package erpc_pkg;
	// Clock rate and speed gate times.
	localparam longint ERPC_CLK_HZ = 125000000;
	localparam longint ERPC_GATE_1S_MS = 1000;
	localparam longint ERPC_GATE_100MS_MS = 100;
	localparam longint ERPC_GATE_10MS_MS = 10;
	localparam int ERPC_CYC_1S = int'((ERPC_CLK_HZ * ERPC_GATE_1S_MS) / 1000);
	localparam int ERPC_CYC_100MS = int'((ERPC_CLK_HZ * ERPC_GATE_100MS_MS) / 1000);
	localparam int ERPC_CYC_10MS = int'((ERPC_CLK_HZ * ERPC_GATE_10MS_MS) / 1000);
	localparam logic [31:0] ERPC_RPM_SCALE = 32'h0000003C;
	// Physical resolution defaults.
	localparam int ERPC_ST_BITS_DEF = 14;
	localparam int ERPC_MT_BITS_DEF = 39;
	// Control word fields.
	localparam int ERPC_CW_ACK = 15;
	localparam int ERPC_CW_PARK = 14;
	localparam int ERPC_CW_ABS = 13;
	localparam int ERPC_CW_PRESET = 12;
	localparam int ERPC_CW_REL = 11;
	localparam logic [15:0] ERPC_CW_RESET = 16'h0000;
	// Status word fields.
	localparam int ERPC_SW_ERR = 15;
	localparam int ERPC_SW_PARK = 14;
	localparam int ERPC_SW_ABS = 13;
	localparam int ERPC_SW_PRESET = 12;
	localparam int ERPC_SW_ACKDET = 11;
	// Speed unit codes.
	localparam logic [1:0] ERPC_SPD_STEPS_S = 2'h0;
	localparam logic [1:0] ERPC_SPD_STEPS_100MS = 2'h1;
	localparam logic [1:0] ERPC_SPD_STEPS_10MS = 2'h2;
	localparam logic [1:0] ERPC_SPD_RPM = 2'h3;
	// Parameter limits and scale factors.
	localparam logic [63:0] ERPC_RANGE_MIN = 64'h0000000000000002;
	localparam logic [11:0] ERPC_LIFE_SCALE = 12'h00A;
	// Preset handshake states.
	typedef enum logic [1:0] {
		ERPC_PS_IDLE = 2'b01,
		ERPC_PS_HOLD = 2'b10
	} erpc_pst_t;
	// Sum modulo r for operands already below r.
	function automatic logic [63:0] erpc_add_mod(input logic [63:0] a, input logic [63:0] b,
		input logic [63:0] r);
		logic [64:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, r}) begin
			s = s - {1'b0, r};
		end
		return s[63:0];
	endfunction
	// Difference modulo r for operands already below r.
	function automatic logic [63:0] erpc_sub_mod(input logic [63:0] a, input logic [63:0] b,
		input logic [63:0] r);
		return (a >= b) ? (a - b) : (a + (r - b));
	endfunction
endpackage

//--- erpc_speed.sv
// Gate-time speed meter over scaled position steps or whole turns.
`timescale 1ns/1ps
module erpc_speed import erpc_pkg::*; #(
	parameter int GATE_1S_CYC = ERPC_CYC_1S,
	parameter int GATE_100MS_CYC = ERPC_CYC_100MS,
	parameter int GATE_10MS_CYC = ERPC_CYC_10MS
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Events and unit.
	input wire logic step_inc,
	input wire logic step_dec,
	input wire logic turn_inc,
	input wire logic turn_dec,
	input wire logic [1:0] unit,
	// Result.
	output logic [31:0] speed
);
	logic [31:0] gate_reg, gate_next;
	logic [31:0] acc_reg, acc_next;
	logic [31:0] speed_reg, speed_next;
	logic [1:0] unit_reg, unit_next;
	logic [31:0] gate_len;
	logic [31:0] acc_sum;
	logic up, dn;
	// Steps are already scaled, so the step units follow the position scaling.
	always_comb begin
		up = (unit == ERPC_SPD_RPM) ? turn_inc : step_inc; // R11
		dn = (unit == ERPC_SPD_RPM) ? turn_dec : step_dec;
		case (unit)
			ERPC_SPD_STEPS_100MS: gate_len = GATE_100MS_CYC[31:0]; // R10
			ERPC_SPD_STEPS_10MS: gate_len = GATE_10MS_CYC[31:0]; // R10
			default: gate_len = GATE_1S_CYC[31:0]; // R10
		endcase
		unit_next = unit;
		gate_next = gate_reg + 32'h00000001;
		// The closing sum is kept apart, so clearing the count cannot zero the result.
		acc_sum = acc_reg + {31'h0, up} - {31'h0, dn};
		acc_next = acc_sum;
		speed_next = speed_reg;
		// RPM counts turns over one second, trading resolution for no divider.
		if (unit != unit_reg) begin
			gate_next = 32'h00000000;
			acc_next = 32'h00000000;
		end else if (gate_reg >= gate_len - 32'h00000001) begin
			gate_next = 32'h00000000;
			acc_next = 32'h00000000;
			speed_next = (unit == ERPC_SPD_RPM) ? acc_sum * ERPC_RPM_SCALE : acc_sum; // R10
		end
	end
	// Registers of the speed meter.
	always_ff @(posedge clk) begin
		if (srst) begin
			gate_reg <= 32'h00000000;
			acc_reg <= 32'h00000000;
			speed_reg <= 32'h00000000;
			unit_reg <= ERPC_SPD_STEPS_S;
		end else begin
			gate_reg <= gate_next;
			acc_reg <= acc_next;
			speed_reg <= speed_next;
			unit_reg <= unit_next;
		end
	end
	assign speed = speed_reg;
endmodule // erpc_speed

//--- erpc_top.sv
// Range, scaling, preset and control-word logic of the absolute encoder.
`timescale 1ns/1ps
module erpc_top import erpc_pkg::*; #(
	parameter int ST_BITS = ERPC_ST_BITS_DEF,
	parameter int MT_BITS = ERPC_MT_BITS_DEF,
	parameter int GATE_1S_CYC = ERPC_CYC_1S,
	parameter int GATE_100MS_CYC = ERPC_CYC_100MS,
	parameter int GATE_10MS_CYC = ERPC_CYC_10MS
) (
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic SRST,
	// Parameter set from the master.
	input wire logic PARAM_LOAD,
	input wire logic PARAM_CLASS4_EN,
	input wire logic PARAM_WORD1_PRESET_EN,
	input wire logic PARAM_SCALING_EN,
	input wire logic PARAM_COMPAT_EN,
	input wire logic PARAM_DIR_CCW,
	input wire logic [31:0] PARAM_UNITS_PER_TURN,
	input wire logic [31:0] PARAM_TOTAL_RANGE,
	input wire logic [31:0] PARAM_TOTAL_RANGE_HI,
	input wire logic [31:0] PARAM_TOTAL_RANGE_LO,
	input wire logic [7:0] PARAM_LIFE_FAILS,
	input wire logic [1:0] PARAM_SPEED_UNIT,
	input wire logic [11:0] LIFE_SIGN_LIMIT_PARAM,
	output logic PARAM_DONE,
	output logic PARAM_REJECT,
	// Acyclic preset and offset values.
	input wire logic PRESET_WRITE,
	input wire logic [63:0] PRESET_VALUE_PARAM,
	output logic [63:0] PRESET_VALUE_PARAM_RD,
	output logic [31:0] PRESET_VALUE_PARAM32_RD,
	output logic [63:0] OFFSET_VALUE_PARAM_RD,
	output logic [31:0] OFFSET_VALUE_PARAM32_RD,
	// Cyclic words.
	input wire logic CTRL_VALID,
	input wire logic [15:0] ENCODER_CONTROL_WORD,
	output logic [15:0] ENCODER_STATUS_WORD,
	output logic [31:0] POSITION_WORD_ONE,
	output logic [31:0] POSITION_WORD_TWO,
	output logic [63:0] POSITION_WORD_THREE,
	output logic [15:0] SPEED_WORD_SHORT,
	output logic [31:0] SPEED_WORD_LONG,
	// Sensor side.
	input wire logic RAW_INC,
	input wire logic RAW_DEC,
	input wire logic SENSOR_FAULT,
	input wire logic [31:0] SENSOR_ERR_CODE,
	output logic SENSOR_ERR_OUT,
	output logic [11:0] LIFE_FAIL_LIMIT
);
	localparam logic [31:0] DEF_UPT = 32'(64'h1 << ST_BITS);
	localparam logic [63:0] DEF_RANGE = 64'h1 << (ST_BITS + MT_BITS);
	// Configuration registers.
	logic cfg_class4_reg, cfg_class4_next;
	logic cfg_w1_reg, cfg_w1_next;
	logic cfg_scale_reg, cfg_scale_next;
	logic cfg_compat_reg, cfg_compat_next;
	logic cfg_ccw_reg, cfg_ccw_next;
	logic [31:0] cfg_upt_reg, cfg_upt_next;
	logic [63:0] cfg_range_reg, cfg_range_next;
	logic [7:0] cfg_fails_reg, cfg_fails_next;
	logic [1:0] cfg_unit_reg, cfg_unit_next;
	logic done_reg, done_next;
	logic reject_reg, reject_next;
	logic chk_accept;
	logic [63:0] chk_range;
	// Position and preset state.
	logic [63:0] raw_pos_reg, raw_pos_next;
	logic [63:0] offset_reg, offset_next;
	logic [31:0] turn_frac_reg, turn_frac_next;
	logic [63:0] preset_reg, preset_next;
	erpc_pst_t pst_reg, pst_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic req_prev_reg, req_prev_next;
	// Error handling state.
	logic err_reg, err_next;
	logic ackdet_reg, ackdet_next;
	logic [31:0] code_reg, code_next;
	// Output words.
	logic [15:0] status_reg, status_next;
	logic [31:0] word1_reg, word1_next;
	logic [31:0] word2_reg, word2_next;
	logic [63:0] word3_reg, word3_next;
	logic [11:0] life_reg, life_next;
	// Working signals.
	logic [31:0] eff_upt;
	logic [63:0] eff_range;
	logic step_inc, step_dec, turn_inc, turn_dec;
	logic preset_fire, parked, pos_fits;
	logic [63:0] pos_cur, neg_preset;
	logic [31:0] speed_long;

	erpc_param_check #(
		.ST_BITS(ST_BITS),
		.MT_BITS(MT_BITS)
	) u_check (
		.units_per_turn(PARAM_UNITS_PER_TURN),
		.total_range(PARAM_TOTAL_RANGE),
		.total_range_hi(PARAM_TOTAL_RANGE_HI),
		.total_range_lo(PARAM_TOTAL_RANGE_LO),
		.accept(chk_accept),
		.eff_range(chk_range)
	);

	// A rejected set leaves the running configuration untouched.
	always_comb begin
		cfg_class4_next = cfg_class4_reg;
		cfg_w1_next = cfg_w1_reg;
		cfg_scale_next = cfg_scale_reg;
		cfg_compat_next = cfg_compat_reg;
		cfg_ccw_next = cfg_ccw_reg;
		cfg_upt_next = cfg_upt_reg;
		cfg_range_next = cfg_range_reg;
		cfg_fails_next = cfg_fails_reg;
		cfg_unit_next = cfg_unit_reg;
		done_next = PARAM_LOAD;
		reject_next = reject_reg;
		if (PARAM_LOAD) begin
			reject_next = !chk_accept; // R02 R05
			if (chk_accept) begin
				cfg_class4_next = PARAM_CLASS4_EN;
				cfg_w1_next = PARAM_WORD1_PRESET_EN;
				cfg_scale_next = PARAM_SCALING_EN;
				cfg_compat_next = PARAM_COMPAT_EN;
				cfg_ccw_next = PARAM_DIR_CCW;
				cfg_upt_next = PARAM_UNITS_PER_TURN;
				cfg_range_next = chk_range;
				cfg_fails_next = PARAM_LIFE_FAILS;
				cfg_unit_next = PARAM_SPEED_UNIT;
			end
		end
		// Compatibility mode scales the byte setting; otherwise the separate limit rules.
		life_next = cfg_compat_reg ? 12'(cfg_fails_reg * ERPC_LIFE_SCALE) : LIFE_SIGN_LIMIT_PARAM; // R09
	end

	// Configuration registers; reset gives the default scaling.
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			cfg_class4_reg <= 1'b0;
			cfg_w1_reg <= 1'b0;
			cfg_scale_reg <= 1'b0;
			cfg_compat_reg <= 1'b0;
			cfg_ccw_reg <= 1'b0;
			cfg_upt_reg <= DEF_UPT; // R08
			cfg_range_reg <= DEF_RANGE; // R08
			cfg_fails_reg <= 8'h01;
			cfg_unit_reg <= ERPC_SPD_STEPS_S;
			done_reg <= 1'b0;
			reject_reg <= 1'b0;
			life_reg <= 12'h000;
		end else begin
			cfg_class4_reg <= cfg_class4_next;
			cfg_w1_reg <= cfg_w1_next;
			cfg_scale_reg <= cfg_scale_next;
			cfg_compat_reg <= cfg_compat_next;
			cfg_ccw_reg <= cfg_ccw_next;
			cfg_upt_reg <= cfg_upt_next;
			cfg_range_reg <= cfg_range_next;
			cfg_fails_reg <= cfg_fails_next;
			cfg_unit_reg <= cfg_unit_next;
			done_reg <= done_next;
			reject_reg <= reject_next;
			life_reg <= life_next;
		end
	end

	// Without class 4 or scaling, the physical default scaling applies; without class 4, the clockwise count applies as well.
	always_comb begin
		eff_upt = (cfg_class4_reg && cfg_scale_reg) ? cfg_upt_reg : DEF_UPT; // R22
		eff_range = (cfg_class4_reg && cfg_scale_reg) ? cfg_range_reg : DEF_RANGE; // R22
		step_inc = (cfg_class4_reg && cfg_ccw_reg) ? RAW_DEC : RAW_INC; // R22
		step_dec = (cfg_class4_reg && cfg_ccw_reg) ? RAW_INC : RAW_DEC;
		turn_inc = step_inc && !step_dec && turn_frac_reg == eff_upt - 32'h00000001;
		turn_dec = step_dec && !step_inc && turn_frac_reg == 32'h00000000;
		parked = ctrl_reg[ERPC_CW_PARK];
		pos_fits = eff_range[63:32] == 32'h00000000;
		pos_cur = erpc_add_mod(raw_pos_reg, offset_reg, eff_range);
		neg_preset = 64'h0 - preset_reg;
		// A held request must not retrigger, so only the rising edge counts.
		preset_fire = ctrl_reg[ERPC_CW_PRESET] && !req_prev_reg && cfg_class4_reg; // R25 R22
	end

	// Position counting, preset handshake and offset arithmetic.
	always_comb begin
		raw_pos_next = raw_pos_reg;
		turn_frac_next = turn_frac_reg;
		offset_next = offset_reg;
		preset_next = PRESET_WRITE ? PRESET_VALUE_PARAM : preset_reg;
		ctrl_next = CTRL_VALID ? ENCODER_CONTROL_WORD : ctrl_reg; // R12
		req_prev_next = ctrl_reg[ERPC_CW_PRESET];
		pst_next = pst_reg;
		if (step_inc && !step_dec) begin
			raw_pos_next = (raw_pos_reg >= eff_range - 64'h1) ? 64'h0 : raw_pos_reg + 64'h1; // R01
			turn_frac_next = turn_inc ? 32'h00000000 : turn_frac_reg + 32'h00000001;
		end else if (step_dec && !step_inc) begin
			raw_pos_next = (raw_pos_reg == 64'h0) ? eff_range - 64'h1 : raw_pos_reg - 64'h1;
			turn_frac_next = turn_dec ? eff_upt - 32'h00000001 : turn_frac_reg - 32'h00000001;
		end
		// The offset is only ever derived here, never loaded from outside.
		if (preset_fire) begin
			if (ctrl_reg[ERPC_CW_REL]) begin
				if (!preset_reg[63]) begin
					offset_next = erpc_add_mod(offset_reg, preset_reg % eff_range, eff_range); // R17
				end else begin
					offset_next = erpc_sub_mod(offset_reg, neg_preset % eff_range, eff_range); // R17
				end
			end else if (preset_reg < eff_range) begin
				offset_next = erpc_sub_mod(preset_reg, raw_pos_next, eff_range); // R18 R20
			end
		end
		case (pst_reg)
			ERPC_PS_IDLE: begin
				if (preset_fire) begin
					pst_next = ERPC_PS_HOLD; // R16
				end
			end
			ERPC_PS_HOLD: begin
				if (!ctrl_reg[ERPC_CW_PRESET]) begin
					pst_next = ERPC_PS_IDLE; // R16
				end
			end
			default: pst_next = ERPC_PS_IDLE;
		endcase
		// A new range invalidates the old count, so counting restarts from zero.
		if (PARAM_LOAD && chk_accept) begin
			raw_pos_next = 64'h0;
			turn_frac_next = 32'h00000000;
			offset_next = 64'h0;
		end
	end

	// Registers of position and preset state.
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			raw_pos_reg <= 64'h0;
			turn_frac_reg <= 32'h00000000;
			offset_reg <= 64'h0;
			preset_reg <= 64'h0;
			ctrl_reg <= ERPC_CW_RESET;
			req_prev_reg <= 1'b0;
			pst_reg <= ERPC_PS_IDLE;
		end else begin
			raw_pos_reg <= raw_pos_next;
			turn_frac_reg <= turn_frac_next;
			offset_reg <= offset_next;
			preset_reg <= preset_next;
			ctrl_reg <= ctrl_next;
			req_prev_reg <= req_prev_next;
			pst_reg <= pst_next;
		end
	end

	// Error latch and acknowledge handshake; parking silences both.
	always_comb begin
		err_next = err_reg;
		ackdet_next = ackdet_reg;
		code_next = code_reg;
		if (parked) begin
			err_next = 1'b0; // R14
			ackdet_next = 1'b0;
		end else begin
			if (ctrl_reg[ERPC_CW_ACK] && err_reg) begin
				ackdet_next = 1'b1; // R13
			end else if (!ctrl_reg[ERPC_CW_ACK] && ackdet_reg) begin
				ackdet_next = 1'b0;
				err_next = SENSOR_FAULT; // R13
			end
			// A fresh fault wins over the clearing acknowledge.
			if (SENSOR_FAULT) begin
				err_next = 1'b1;
				code_next = SENSOR_ERR_CODE;
			end
		end
	end

	// Output words, built from the next error and handshake state and from the registered position.
	always_comb begin
		status_next = 16'h0000;
		status_next[ERPC_SW_ERR] = err_next;
		status_next[ERPC_SW_PARK] = parked; // R14
		status_next[ERPC_SW_ABS] = !err_next && !parked && pos_fits; // R15
		status_next[ERPC_SW_PRESET] = pst_next == ERPC_PS_HOLD; // R16
		status_next[ERPC_SW_ACKDET] = ackdet_next;
		word1_next = cfg_w1_reg ? pos_cur[31:0] : raw_pos_reg[31:0]; // R23
		word3_next = pos_cur; // R23
		if (err_next) begin
			word2_next = code_next; // R24
		end else if (parked || !pos_fits) begin
			word2_next = 32'h00000000; // R14
		end else begin
			word2_next = pos_cur[31:0]; // R15 R23
		end
	end

	// Registers of the error state and output words.
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			err_reg <= 1'b0;
			ackdet_reg <= 1'b0;
			code_reg <= 32'h00000000;
			status_reg <= 16'h0000;
			word1_reg <= 32'h00000000;
			word2_reg <= 32'h00000000;
			word3_reg <= 64'h0;
		end else begin
			err_reg <= err_next;
			ackdet_reg <= ackdet_next;
			code_reg <= code_next;
			status_reg <= status_next;
			word1_reg <= word1_next;
			word2_reg <= word2_next;
			word3_reg <= word3_next;
		end
	end

	erpc_speed #(
		.GATE_1S_CYC(GATE_1S_CYC),
		.GATE_100MS_CYC(GATE_100MS_CYC),
		.GATE_10MS_CYC(GATE_10MS_CYC)
	) u_speed (
		.clk(CLK_SYS),
		.srst(SRST),
		.step_inc(step_inc),
		.step_dec(step_dec),
		.turn_inc(turn_inc),
		.turn_dec(turn_dec),
		.unit(cfg_unit_reg),
		.speed(speed_long)
	);

	// Port assignments; the 32-bit views mirror the wide values.
	assign PARAM_DONE = done_reg;
	assign PARAM_REJECT = reject_reg;
	assign PRESET_VALUE_PARAM_RD = preset_reg;
	assign PRESET_VALUE_PARAM32_RD = preset_reg[31:0]; // R21
	assign OFFSET_VALUE_PARAM_RD = offset_reg;
	assign OFFSET_VALUE_PARAM32_RD = offset_reg[31:0]; // R21
	assign ENCODER_STATUS_WORD = status_reg;
	assign POSITION_WORD_ONE = word1_reg;
	assign POSITION_WORD_TWO = word2_reg;
	assign POSITION_WORD_THREE = word3_reg;
	assign SPEED_WORD_LONG = speed_long;
	assign SPEED_WORD_SHORT = speed_long[15:0];
	assign SENSOR_ERR_OUT = err_reg && !parked; // R14
	assign LIFE_FAIL_LIMIT = life_reg;

	// Checks on the documented behaviour.
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	a_wrap_to_zero: assert property ( // R01
		step_inc && !step_dec && !PARAM_LOAD && raw_pos_reg == eff_range - 64'h1
		|=> raw_pos_reg == 64'h0)
		else $error("position did not wrap to zero at the range end");
	a_short_range_reject: assert property ( // R02
		PARAM_LOAD && PARAM_TOTAL_RANGE == 32'h00000001
		|=> PARAM_REJECT && PARAM_DONE)
		else $error("range below two was not rejected");
	a_zero_range_reject: assert property ( // R05
		PARAM_LOAD && PARAM_TOTAL_RANGE == 32'h0 && PARAM_TOTAL_RANGE_HI == 32'h0
		&& PARAM_TOTAL_RANGE_LO == 32'h0 ##1 !PARAM_LOAD
		|-> PARAM_REJECT && $stable(cfg_range_reg))
		else $error("all-zero range set was accepted");
	a_preset_ack_rise: assert property ( // R16
		preset_fire |=> ENCODER_STATUS_WORD[ERPC_SW_PRESET])
		else $error("preset executed flag did not rise");
	a_preset_ack_fall: assert property ( // R16
		ENCODER_STATUS_WORD[ERPC_SW_PRESET] && !ctrl_reg[ERPC_CW_PRESET]
		|=> !ENCODER_STATUS_WORD[ERPC_SW_PRESET])
		else $error("preset executed flag did not clear");
	a_preset_single: assert property ( // R25
		preset_fire |=> !preset_fire [*2])
		else $error("held preset request fired twice");
	a_no_preset_off: assert property ( // R22
		!cfg_class4_reg |-> !preset_fire ##1 !ENCODER_STATUS_WORD[ERPC_SW_PRESET])
		else $error("preset ran with class 4 disabled");
	a_abs_preset_value: assert property ( // R18
		preset_fire && !ctrl_reg[ERPC_CW_REL] && preset_reg < eff_range && !RAW_INC
		&& !RAW_DEC && !PARAM_LOAD |=> pos_cur == $past(preset_reg))
		else $error("absolute preset did not load the preset value");
	a_park_status: assert property ( // R14
		parked |=> ENCODER_STATUS_WORD[ERPC_SW_PARK] && !SENSOR_ERR_OUT
		&& !ENCODER_STATUS_WORD[ERPC_SW_ABS])
		else $error("parking did not show or silence errors");
	a_err_code_word: assert property ( // R24
		ENCODER_STATUS_WORD[ERPC_SW_ERR] |-> POSITION_WORD_TWO == code_reg
		&& !ENCODER_STATUS_WORD[ERPC_SW_ABS])
		else $error("error code missing from word two");
	a_life_limit: assert property ( // R09
		cfg_compat_reg ##1 cfg_compat_reg && $stable(cfg_fails_reg)
		|-> LIFE_FAIL_LIMIT == 12'(cfg_fails_reg * ERPC_LIFE_SCALE))
		else $error("life-sign limit is not ten times the setting");

	c_abs_preset: cover property (preset_fire && !ctrl_reg[ERPC_CW_REL]);
	c_rel_preset: cover property (preset_fire && ctrl_reg[ERPC_CW_REL]);
	c_err_ack: cover property (ENCODER_STATUS_WORD[ERPC_SW_ACKDET] ##[1:20] !err_reg);
	c_reject: cover property (PARAM_LOAD ##1 PARAM_REJECT);
endmodule // erpc_top

//--- erpc_top_bench.sv
// Self-checking bench for the encoder range and preset control block.
`timescale 1ns/1ps
module erpc_top_bench;
	import erpc_pkg::*;
	logic CLK_SYS = 0, SRST = 1, PARAM_LOAD = 0, PARAM_CLASS4_EN = 1, PARAM_COMPAT_EN = 0;
	logic PARAM_WORD1_PRESET_EN = 1, PARAM_SCALING_EN = 1, PARAM_DIR_CCW = 0, PRESET_WRITE = 0;
	logic RAW_INC = 0, RAW_DEC = 0, SENSOR_FAULT = 0, CTRL_VALID, PARAM_DONE, PARAM_REJECT;
	logic SENSOR_ERR_OUT;
	logic [31:0] PARAM_UNITS_PER_TURN = 32'h10, PARAM_TOTAL_RANGE, PARAM_TOTAL_RANGE_HI;
	logic [31:0] PARAM_TOTAL_RANGE_LO, SENSOR_ERR_CODE = 32'h5A5A, SPEED_WORD_LONG;
	logic [31:0] PRESET_VALUE_PARAM32_RD, OFFSET_VALUE_PARAM32_RD, POSITION_WORD_ONE;
	logic [31:0] POSITION_WORD_TWO;
	logic [63:0] PRESET_VALUE_PARAM = 64'h0, PRESET_VALUE_PARAM_RD, OFFSET_VALUE_PARAM_RD;
	logic [63:0] POSITION_WORD_THREE;
	logic [15:0] ENCODER_CONTROL_WORD, ENCODER_STATUS_WORD, SPEED_WORD_SHORT;
	logic [11:0] LIFE_SIGN_LIMIT_PARAM = 12'h007, LIFE_FAIL_LIMIT;
	logic [7:0] PARAM_LIFE_FAILS = 8'h03;
	logic [1:0] PARAM_SPEED_UNIT = 2'h0;
	logic [4:0] cmd = 5'h00;
	int n_mismatch = 0, checked = 0, cyc = 0;
	// Small physical resolution keeps wrap tests short.
	erpc_top #(.ST_BITS(4), .MT_BITS(2), .GATE_1S_CYC(40), .GATE_100MS_CYC(20),
		.GATE_10MS_CYC(10)) dut (.*);
	erpc_master_model master (.clk(CLK_SYS), .srst(SRST), .cmd(cmd), .ctrl_valid(CTRL_VALID),
		.ctrl_word(ENCODER_CONTROL_WORD));
	// Clock and hang guard.
	always #4 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs always move one nanosecond after the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task automatic load(input logic [31:0] rng, hi, lo, input logic rej);
		{PARAM_TOTAL_RANGE, PARAM_TOTAL_RANGE_HI, PARAM_TOTAL_RANGE_LO} = {rng, hi, lo};
		PARAM_LOAD = 1;
		tick(1);
		PARAM_LOAD = 0;
		cmp(PARAM_DONE, 1);
		cmp(PARAM_REJECT, rej);
		tick(1);
	endtask
	task automatic steps(input int n);
		repeat (n) begin
			RAW_INC = 1;
			tick(1);
			RAW_INC = 0;
			tick(1);
		end
	endtask
	task automatic preset(input logic [63:0] v, input logic [4:0] c);
		PRESET_VALUE_PARAM = v;
		PRESET_WRITE = 1;
		tick(1);
		PRESET_WRITE = 0;
		cmp(PRESET_VALUE_PARAM32_RD, v[31:0]);
		cmd = c;
	endtask
	// Bounded wait on one status bit, then compare it.
	task automatic wait_st(input int b, input logic v);
		int k;
		k = 0;
		while (ENCODER_STATUS_WORD[b] !== v && k < 20) begin
			tick(1);
			k++;
		end
		cmp(ENCODER_STATUS_WORD[b], v);
	endtask
	initial begin
		tick(8);
		SRST = 0;
		tick(2);
		cmp(LIFE_FAIL_LIMIT, 12'h007);
		load(32'h20, 0, 0, 0);
		load(32'h1, 0, 0, 1);
		load(0, 0, 0, 1);
		load(32'h20, 0, 32'h30, 1);
		load(0, 0, 32'h20, 0);
		steps(33);
		cmp(POSITION_WORD_THREE, 64'h1);
		// Presets are asked for with the shaft standing; words follow the flag by one edge.
		preset(64'hA, 5'h02);
		wait_st(12, 1);
		tick(1);
		cmp(POSITION_WORD_THREE, 64'hA);
		cmp(OFFSET_VALUE_PARAM_RD, 64'h9);
		cmp(OFFSET_VALUE_PARAM32_RD, 32'h9);
		steps(1);
		cmp(POSITION_WORD_THREE, 64'hB);
		cmd = 5'h00;
		wait_st(12, 0);
		preset(64'hFFFFFFFFFFFFFFFD, 5'h03);
		wait_st(12, 1);
		tick(1);
		cmp(POSITION_WORD_THREE, 64'h8);
		cmp(POSITION_WORD_ONE, 32'h8);
		cmp(POSITION_WORD_TWO, 32'h8);
		cmd = 5'h00;
		wait_st(12, 0);
		// Class 4 off: default range applies and presets are ignored.
		PARAM_CLASS4_EN = 0;
		PARAM_COMPAT_EN = 1;
		PARAM_SPEED_UNIT = 2'h2;
		load(32'h20, 0, 0, 0);
		cmd = 5'h02;
		steps(33);
		cmp(ENCODER_STATUS_WORD[12], 0);
		cmp(POSITION_WORD_THREE, 64'h21);
		cmp(LIFE_FAIL_LIMIT, 12'h01E);
		// A step every cycle fills each ten-cycle gate with ten steps.
		RAW_INC = 1;
		tick(30);
		RAW_INC = 0;
		cmp(SPEED_WORD_LONG, 32'hA);
		cmp(SPEED_WORD_SHORT, 16'hA);
		// Sensor error, acknowledge, then parking.
		cmd = 5'h00;
		SENSOR_FAULT = 1;
		tick(4);
		cmp(ENCODER_STATUS_WORD[15], 1);
		cmp(POSITION_WORD_TWO, 32'h5A5A);
		cmd = 5'h10;
		wait_st(11, 1);
		cmd = 5'h00;
		SENSOR_FAULT = 0;
		wait_st(11, 0);
		cmp(ENCODER_STATUS_WORD[15], 0);
		SENSOR_FAULT = 1;
		cmd = 5'h08;
		wait_st(14, 1);
		cmp(SENSOR_ERR_OUT, 0);
		cmp(POSITION_WORD_TWO, 32'h0);
		give_verdict();
	end
endmodule // erpc_top_bench
